// File: tb/sacs_cmp_model.sv
// comparator model answering each trial of the sequencer
`timescale 1ns/1ns
module sacs_cmp_model (
  input  wire logic [11:0] dacCode,
  input  wire logic [11:0] target,
  output logic             cmpHigh
);
  // ****************
  // trial decision
  // ****************
  function automatic int low_bit(input logic [11:0] c);
    int k;
    k = 0;
    for (int i = 11; i >= 0; i--)
    begin
      if (c[i])
        k = i;
    end
    return k;
  endfunction : low_bit

  // the trial bit is the lowest set bit; sign sense inverted for two's complement
  always_comb cmpHigh = (low_bit(dacCode) == 11) ? ~target[11] : target[low_bit(dacCode)];
endmodule : sacs_cmp_model

// File: tb/tb_sar_conversion_sequencer.sv
// self-checking bench of the conversion sequencer
`timescale 1ns/1ns
module tb_sar_conversion_sequencer;
  localparam int BC = 5;
  logic        core_clk = 1'b0, rstn = 1'b0, clkEn = 1'b1, csN = 1'b0, startN = 1'b1;
  logic        busy_n, sampleHold, zeroSwitchOn, capToGround, dataValid, cmpHigh;
  logic [11:0] dacCode, dataOut;
  logic [11:0] target = 12'h000;
  int          n_fail = 0;
  int          compares = 0;
  int          frz = 0;

  always #2 core_clk = ~core_clk;

  sacs_sequencer #(.RES_BITS(12), .BIT_CYC(BC)) i_dut (.core_clk(core_clk), .rstn(rstn), .clkEn(clkEn),
    .chipSelect_n(csN), .conversion_start_n(startN), .cmpHigh(cmpHigh), .busy_n(busy_n),
    .sampleHold(sampleHold), .zeroSwitchOn(zeroSwitchOn), .capToGround(capToGround),
    .dacCode(dacCode), .dataOut(dataOut), .dataValid(dataValid));
  sacs_cmp_model i_cmp (.dacCode(dacCode), .target(target), .cmpHigh(cmpHigh));

  // ****************
  // helpers
  // ****************
  function automatic int exp_cyc();
    return 2 + 12 * BC + frz;
  endfunction : exp_cyc

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  // poke toggles the start pin mid-conversion, stopping well before the load
  task automatic conv(input logic [11:0] t, input bit poke);
    int n;
    @(negedge core_clk);
    target = t;
    startN = 1'b0;
    @(negedge core_clk);
    chk(12'(busy_n), 12'h000);
    @(negedge core_clk);
    n = 1;
    chk(12'({busy_n, zeroSwitchOn, capToGround, sampleHold}), 12'h003);
    while (dataValid !== 1'b1 && n < 200)
    begin
      @(negedge core_clk);
      n++;
      clkEn = !(n >= 20 && n < 20 + frz);
      if (poke && n < 55)
        startN = ~startN;
    end
    chk(12'(n), 12'(exp_cyc()));
    chk(dataOut, t);
    chk(12'({busy_n, zeroSwitchOn, capToGround, sampleHold}), 12'h00c);
    startN = 1'b1;
    repeat (14) @(negedge core_clk);
    $display("conversion of %h done", t);
  endtask : conv

  // ****************
  // tests
  // ****************
  initial
  begin
    void'($urandom(42484));
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    chk(12'({busy_n, zeroSwitchOn, capToGround, sampleHold}), 12'h00c);
    chk(dataOut, 12'h000);
    $display("reset test done");
    conv(12'h000, 1'b0);
    conv(12'h7ff, 1'b1);
    conv(12'h800, 1'b0);
    conv(12'hfff, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      frz = i % 4;
      repeat (i) @(negedge core_clk);
      conv(12'($urandom), i[0]);
    end
    frz = 0;
    csN = 1'b1;
    startN = 1'b0;
    repeat (5) @(negedge core_clk);
    chk(12'(busy_n), 12'h001);
    startN = 1'b1;
    @(negedge core_clk);
    csN = 1'b0;
    $display("chip select test done");
    end_of_test();
  end

  initial
  begin
    #40000;
    n_fail++;
    end_of_test();
  end
endmodule : tb_sar_conversion_sequencer

// File: verilog/sacs_bit_pacer.sv
// internal bit-decision clock: one tick every period cycles
`timescale 1ns/1ns
module sacs_bit_pacer #(
  parameter int PERIOD = 5
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic clkEn,
  input  wire logic run,
  output logic      tick
);
  logic [7:0] cnt_q;

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_q <= 8'h00;
    end
    else if (clkEn)
    begin
      if (!run || cnt_q == 8'(PERIOD - 1))
      begin
        cnt_q <= 8'h00;
      end
      else
      begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end

  assign tick = run && (cnt_q == 8'(PERIOD - 1));
endmodule : sacs_bit_pacer

// File: verilog/sacs_params.svh
// timing and layout constants of the conversion sequencer
`ifndef SACS_PARAMS_SVH
`define SACS_PARAMS_SVH
`define SACS_CLK_PERIOD_NS 4
`define SACS_RES_BITS      12
`define SACS_ACQ_MIN_NS    50
`define SACS_ACQ_CYC       ((`SACS_ACQ_MIN_NS + `SACS_CLK_PERIOD_NS - 1) / `SACS_CLK_PERIOD_NS)
`define SACS_BIT_NS        20
`define SACS_BIT_CYC       (`SACS_BIT_NS / `SACS_CLK_PERIOD_NS)
`define SACS_RESULT_RST    12'h000
`endif

// File: verilog/sacs_pkg.sv
// types of the conversion sequencer
package sacs_pkg;
  typedef enum logic [1:0] {SACS_ACQUIRE, SACS_CLEAR, SACS_CONVERT, SACS_LOAD} sacs_state_t;
endpackage : sacs_pkg

// File: verilog/sacs_sequencer.sv
// successive-approximation conversion sequencer
`timescale 1ns/1ns
`include "sacs_params.svh"
module sacs_sequencer
  import sacs_pkg::*;
#(
  parameter int RES_BITS = `SACS_RES_BITS,
  parameter int BIT_CYC  = `SACS_BIT_CYC
) (
  input  wire logic                core_clk,
  input  wire logic                rstn,
  input  wire logic                clkEn,
  input  wire logic                chipSelect_n,
  input  wire logic                conversion_start_n,
  input  wire logic                cmpHigh,
  output logic                     busy_n,
  output logic                     sampleHold,
  output logic                     zeroSwitchOn,
  output logic                     capToGround,
  output logic [RES_BITS-1:0]      dacCode,
  output logic [RES_BITS-1:0]      dataOut,
  output logic                     dataValid
);
  // ****************************************
  // state
  // ****************************************
  sacs_state_t               state_q;
  logic                      startPrev_q;
  logic [RES_BITS-1:0]       successive_approx_reg_q;
  logic [RES_BITS-1:0]       trialBit_q;
  logic                      tick;
  logic                      startFall;

  // a fall is only seen while selected; held-low start never retriggers
  assign startFall = startPrev_q && !conversion_start_n && !chipSelect_n;

  sacs_bit_pacer #(.PERIOD(BIT_CYC)) uPacer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clkEn    (clkEn),
    .run      (state_q == SACS_CONVERT),
    .tick     (tick)
  );

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      startPrev_q <= 1'b1;
    end
    else if (clkEn)
    begin
      startPrev_q <= conversion_start_n;
    end
  end

  // ****************************************
  // sequencing
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q                 <= SACS_ACQUIRE;
      successive_approx_reg_q <= '0;
      trialBit_q              <= '0;
    end
    else if (clkEn)
    begin
      case (state_q)
        SACS_ACQUIRE:
        begin
          if (startFall)
          begin
            state_q <= SACS_CLEAR;
          end
        end
        SACS_CLEAR:
        begin
          successive_approx_reg_q <= '0;
          trialBit_q              <= {1'b1, {(RES_BITS-1){1'b0}}};
          state_q                 <= SACS_CONVERT;
        end
        SACS_CONVERT:
        begin
          // starts are not looked at here, so a cycle cannot restart
          if (tick)
          begin
            // msb trial is the sign bit, so its sense is inverted for two's complement
            if (trialBit_q[RES_BITS-1] ? !cmpHigh : cmpHigh)
            begin
              successive_approx_reg_q <= successive_approx_reg_q | trialBit_q;
            end
            trialBit_q <= trialBit_q >> 1;
            if (trialBit_q[0])
            begin
              state_q <= SACS_LOAD;
            end
          end
        end
        SACS_LOAD:
        begin
          state_q <= SACS_ACQUIRE;
        end
        default:
        begin
          state_q <= SACS_ACQUIRE;
        end
      endcase
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      busy_n       <= 1'b1;
      sampleHold   <= 1'b0;
      zeroSwitchOn <= 1'b1;
      capToGround  <= 1'b0;
      dacCode      <= '0;
      dataOut      <= RES_BITS'(`SACS_RESULT_RST);
      dataValid    <= 1'b0;
    end
    else if (clkEn)
    begin
      dataValid <= 1'b0;
      if (state_q == SACS_ACQUIRE && startFall)
      begin
        busy_n       <= 1'b0;
        sampleHold   <= 1'b1;
        zeroSwitchOn <= 1'b0;
        capToGround  <= 1'b1;
      end
      if (state_q == SACS_CONVERT)
      begin
        // trial code drives the dac: accepted bits plus current trial
        dacCode <= successive_approx_reg_q | trialBit_q;
      end
      if (state_q == SACS_LOAD)
      begin
        dataOut      <= successive_approx_reg_q;
        dataValid    <= 1'b1;
        busy_n       <= 1'b1;
        sampleHold   <= 1'b0;
        zeroSwitchOn <= 1'b1;
        capToGround  <= 1'b0;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_launch;
    $fell(busy_n);
  endsequence
  property p_launch_cause;
    @(posedge core_clk) disable iff (!rstn) s_launch |-> $past(!chipSelect_n) && $past(startFall);
  endproperty
  a_launch_cause: assert property (p_launch_cause) else $error("conversion launched without start");
  property p_clear;
    @(posedge core_clk) disable iff (!rstn) (state_q == SACS_CLEAR && clkEn) |=> successive_approx_reg_q == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("register not cleared");
  property p_no_restart;
    @(posedge core_clk) disable iff (!rstn) (state_q == SACS_CONVERT && startFall) |=> state_q != SACS_CLEAR;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("conversion restarted");
  property p_msb_first;
    @(posedge core_clk) disable iff (!rstn) (state_q == SACS_CLEAR && clkEn) |=> trialBit_q[RES_BITS-1];
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first trial not msb");
  property p_switches;
    @(posedge core_clk) disable iff (!rstn)
      zeroSwitchOn == !capToGround && zeroSwitchOn == busy_n && (state_q != SACS_CONVERT || capToGround);
  endproperty
  a_switches: assert property (p_switches) else $error("switch phase wrong");
  property p_load;
    @(posedge core_clk) disable iff (!rstn) $rose(dataValid) |-> dataOut == $past(successive_approx_reg_q);
  endproperty
  a_load: assert property (p_load) else $error("result not latched");
  property p_sample;
    @(posedge core_clk) disable iff (!rstn) $rose(sampleHold) |-> $fell(busy_n);
  endproperty
  a_sample: assert property (p_sample) else $error("sample not at launch");
  property p_busy_high;
    @(posedge core_clk) disable iff (!rstn) $rose(dataValid) |-> busy_n;
  endproperty
  a_busy_high: assert property (p_busy_high) else $error("busy not released");
  property p_busy_low;
    @(posedge core_clk) disable iff (!rstn) (state_q == SACS_CONVERT) |-> !busy_n;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy high during conversion");
  property p_valid_pulse;
    @(posedge core_clk) disable iff (!rstn) (dataValid && clkEn) |=> !dataValid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("result strobe longer than one cycle");
  // a consumed tick restarts the pacer, so the next decision is a full bit period away
  sequence s_bit_gap;
    !tick [*4];
  endsequence
  property p_bit_pace;
    @(posedge core_clk) disable iff (!rstn) (tick && clkEn) |=> s_bit_gap;
  endproperty
  a_bit_pace: assert property (p_bit_pace) else $error("bit decisions too close");
  property p_freeze;
    @(posedge core_clk) disable iff (!rstn) !clkEn |=> $stable(state_q) && $stable(busy_n) && $stable(dataOut);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
endmodule : sacs_sequencer
